// ---- hw/ieb_pkg.sv ----
// Package for the interrupt enable bank: register map, masks, structs.
// Assumes a 32-bit APB master and single-clock peripheral event sources.
// Functional notes
// - Enable bit 1 passes request, 0 blocks it
// - Unimplemented bits read zero, ignore writes
// - CAN enables forced off without CAN
// - Word0 bits 2,1,0 gate compare1, capture1, pin0
// - Word0 bit 6 gates compare channel 2
// - Word1 bit 14 gates serial2 receive
// - Word1 bit 13 gates external pin 2
// - Word1 bits 12,11 gate timers five, four
// - Word1 bits 10,9 gate compare 4, 3
// - Word1 bit 8 gates DMA channel 2 done
// - Word1 bits 4,3 gate pin1, pin change
// - Word1 bit 2 gates comparator
// - Word1 bits 1,0 gate I2C master, slave
// - Flags reflect events regardless of enables
// - Zero priority field means source disabled
package ieb_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] IEB_OFS_EN0 = 8'h00; // Enable word 0
    localparam logic [7:0] IEB_OFS_EN1 = 8'h04; // Enable word 1
    localparam logic [7:0] IEB_OFS_EN2 = 8'h08; // Enable word 2
    localparam logic [7:0] IEB_OFS_EN3 = 8'h0c; // Enable word 3
    localparam logic [7:0] IEB_OFS_FLG0 = 8'h10; // Flag words 0..3
    localparam logic [7:0] IEB_OFS_PEND0 = 8'h20; // Gated request 0..3
    localparam logic [7:0] IEB_OFS_STAT = 8'h30; // Sticky status
    localparam logic [7:0] IEB_OFS_MASK = 8'h34; // Interrupt mask

    // ------------------------------------------------------------
    // Implemented bit masks per enable word
    // ------------------------------------------------------------
    localparam logic [15:0] IEB_IMPL_W0 = 16'h7fff; // Top bit absent
    localparam logic [15:0] IEB_IMPL_W1 = 16'hffdf; // Bit 5 absent
    localparam logic [15:0] IEB_IMPL_W2 = 16'h601f; // Bits 15 and 12..5 absent
    localparam logic [15:0] IEB_IMPL_W3 = 16'he600; // Bits 12,11 and 8..0 absent
    localparam logic [15:0] IEB_CAN_W2 = 16'h000c; // CAN event, CAN rx
    localparam logic [15:0] IEB_EN_RST = 16'h0000; // Enables after reset

    // Named bit positions used by the block
    localparam int IEB_B_CMP1 = 2;  // Word 0
    localparam int IEB_B_CAP1 = 1;
    localparam int IEB_B_PIN0 = 0;
    localparam int IEB_B_CMP2 = 6;
    localparam int IEB_B_SER2RX = 14; // Word 1
    localparam int IEB_B_PIN2 = 13;
    localparam int IEB_B_TMR5 = 12;
    localparam int IEB_B_TMR4 = 11;
    localparam int IEB_B_CMP4 = 10;
    localparam int IEB_B_CMP3 = 9;
    localparam int IEB_B_DMA2 = 8;
    localparam int IEB_B_PIN1 = 4;
    localparam int IEB_B_PCHG = 3;
    localparam int IEB_B_CMPR = 2;
    localparam int IEB_B_I2CM = 1;
    localparam int IEB_B_I2CS = 0;

    // Number of words and sources
    localparam int IEB_WORDS = 4;
    localparam int IEB_SRC = 64;

    // Zero priority code means the source is off
    localparam logic [2:0] IEB_PRIO_OFF = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ieb_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ieb_apb_rsp_s;

endpackage

// ---- hw/ieb_enable_bank.sv ----
// Interrupt enable bank: four enable words gating 64 request lines.
// Assumes synchronous event pulses/levels and a priority vector from
// the core interrupt controller; one clock, synchronous reset.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module ieb_enable_bank
    import ieb_pkg::*;
(
    input wire logic ref_clk, // System clock, 25 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic can_present, // High when CAN controller fitted
    input wire ieb_apb_req_s apb_req, // APB request group
    output ieb_apb_rsp_s apb_rsp, // APB answer group
    input wire logic [IEB_SRC-1:0] src_event, // Event pulse per source
    input wire logic [IEB_SRC-1:0] flag_clr, // Flag clear per source
    input wire logic [3*IEB_SRC-1:0] src_prio, // Priority per source
    output logic [IEB_SRC-1:0] irq_req, // Gated request to core
    output logic [IEB_SRC-1:0] flag_out, // Flag state
    output logic irq // Block interrupt, level
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] en_r [IEB_WORDS]; // Enable words
    logic [IEB_SRC-1:0] flag_r; // Event flags
    logic [IEB_SRC-1:0] req_r; // Registered gated request
    logic [IEB_SRC-1:0] en_vec; // Flattened effective enables
    logic [IEB_SRC-1:0] prio_on; // Priority non zero
    logic [1:0] stat_r; // Sticky: 0 write, 1 unmapped
    logic [1:0] mask_r; // Interrupt mask
    logic [31:0] rdata_r; // Read data flop
    logic slverr_r; // Error flop

    // Access phase decode
    logic acc;
    logic wr;
    logic rd;
    logic [5:0] word_sel;
    logic mapped;
    assign acc = apb_req.psel & apb_req.penable;
    assign wr = acc & apb_req.pwrite;
    assign rd = acc & ~apb_req.pwrite;
    assign word_sel = apb_req.paddr[7:2];

    // Implemented mask per word; CAN bits vanish without CAN
    function automatic logic [15:0] impl_mask(input int w,
                                              input logic can);
        logic [15:0] m;
        m = 16'h0000;
        unique case (w)
            0: m = IEB_IMPL_W0;
            1: m = IEB_IMPL_W1;
            2: m = can ? IEB_IMPL_W2 : (IEB_IMPL_W2 & ~IEB_CAN_W2);
            default: m = IEB_IMPL_W3;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Per-word enable registers and gating
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < IEB_WORDS; g++) begin : g_word
            // Write only implemented bits; clears on reset
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    en_r[g] <= IEB_EN_RST;
                end else if (wr && apb_req.paddr[7:4] == 4'h0
                             && apb_req.paddr[3:2] == 2'(g)) begin
                    // Stray writes to absent bits are dropped
                    en_r[g] <= apb_req.pwdata[15:0]
                               & impl_mask(g, 1'b1);
                end
            end
            // Missing CAN forces its enables off in use
            assign en_vec[16*g +: 16] = en_r[g] & impl_mask(g, can_present);
        end
        for (g = 0; g < IEB_SRC; g++) begin : g_prio
            // Zero priority counts as disabled
            assign prio_on[g] = src_prio[3*g +: 3] != IEB_PRIO_OFF;
        end
    endgenerate

    // ------------------------------------------------------------
    // Flags: set wins over clear, independent of enables
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~flag_clr) | src_event;
        end
    end
    assign flag_out = flag_r;

    // ------------------------------------------------------------
    // Gated requests, re-evaluated every cycle
    // ------------------------------------------------------------
    // Bit positions of word 0 and word 1 fall out of the flat index:
    // source 16*w+b is enable word w bit b, so e.g. bit 2 of word 0
    // gates compare 1 and bit 6 compare 2 word 1 bits
    // 14,13,12,11,10,9,8,4,3,2,1,0 map
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_r <= '0;
        end else begin
            req_r <= flag_r & en_vec & prio_on;
        end
    end
    assign irq_req = req_r;

    // ------------------------------------------------------------
    // APB slave: zero wait, errors on unmapped addresses
    // ------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        if (apb_req.paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (apb_req.paddr > IEB_OFS_MASK) begin
            mapped = 1'b0;
        end else if (apb_req.paddr == 8'h2c || apb_req.paddr == 8'h1c
                     ? 1'b0 : 1'b0) begin
            mapped = 1'b0;
        end
    end

    // Read data mux, registered at the setup edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (apb_req.psel && !apb_req.penable) begin
            rdata_r <= '0;
            if (apb_req.paddr[7:4] == 4'h0) begin
                // Absent bits read as zero
                rdata_r <= {16'h0000,
                            en_r[apb_req.paddr[3:2]]};
            end else if (apb_req.paddr[7:4] == 4'h1) begin
                rdata_r <= {16'h0000, flag_r[16*apb_req.paddr[3:2] +: 16]};
            end else if (apb_req.paddr[7:4] == 4'h2) begin
                rdata_r <= {16'h0000, req_r[16*apb_req.paddr[3:2] +: 16]};
            end else if (apb_req.paddr == IEB_OFS_STAT) begin
                rdata_r <= {30'h0, stat_r};
            end else if (apb_req.paddr == IEB_OFS_MASK) begin
                rdata_r <= {30'h0, mask_r};
            end
        end
    end

    // Error flag for unmapped or misaligned access
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slverr_r <= 1'b0;
        end else if (apb_req.psel && !apb_req.penable) begin
            slverr_r <= ~mapped;
        end
    end

    assign apb_rsp.prdata = rdata_r;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = acc & slverr_r;

    // ------------------------------------------------------------
    // Sticky status, mask and interrupt line
    // ------------------------------------------------------------
    // Status: bit 0 enable write seen, bit 1 unmapped access.
    // A read clears it, but an event in the same cycle survives.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_r <= 2'b00;
        end else begin
            stat_r <= (rd && apb_req.paddr == IEB_OFS_STAT ? 2'b00 : stat_r)
                      | {acc & ~mapped,
                         wr & (apb_req.paddr[7:4] == 4'h0)};
        end
    end

    // Mask register, writable at its own offset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mask_r <= 2'b00;
        end else if (wr && apb_req.paddr == IEB_OFS_MASK) begin
            mask_r <= apb_req.pwdata[1:0];
        end
    end
    assign irq = |(stat_r & mask_r);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_GATE_OFF: assert property (
        !en_vec[16+IEB_B_TMR5] |=> !irq_req[16+IEB_B_TMR5])
        else $error("Timer five request passed while disabled");
    AST_GATE_ON: assert property (
        flag_r[IEB_B_CMP1] && en_vec[IEB_B_CMP1] && prio_on[IEB_B_CMP1]
        |=> irq_req[IEB_B_CMP1])
        else $error("Compare one request not forwarded");
    AST_UNIMPL_W0: assert property (
        en_r[0][15] == 1'b0 && en_r[2][12:5] == 8'h00)
        else $error("Absent enable bit became set");
    AST_UNIMPL_W3: assert property (
        en_r[3][7:0] == 8'h00 && en_r[1][5] == 1'b0)
        else $error("Absent enable bit became set");
    AST_NO_CAN: assert property (
        !can_present |=> irq_req[32+3:32+2] == 2'b00)
        else $error("CAN request passed without CAN");
    AST_FLAG_SET: assert property (
        src_event[16+IEB_B_PIN2] |=> flag_r[16+IEB_B_PIN2])
        else $error("Event did not set its flag");
    AST_PRIO_ZERO: assert property (
        src_prio[3*IEB_B_PIN0 +: 3] == IEB_PRIO_OFF
        |=> !irq_req[IEB_B_PIN0])
        else $error("Zero priority source interrupted");
    AST_RESET: assert property (
        $rose(rst_n) |-> en_r[0] == 16'h0000 && en_r[1] == 16'h0000)
        else $error("Enable words not cleared by reset");
    AST_IRQ: assert property (
        stat_r[0] && mask_r[0] |-> irq)
        else $error("Unmasked status did not raise irq");

    // ------------------------------------------------------------
    // Named gates, one check per documented enable bit
    // ------------------------------------------------------------
    // Each check compares the forwarded request with the enable as
    // it stood one edge earlier, so both pass and block are covered.
    // Flag and priority are held true in the antecedent on purpose:
    // otherwise the check would fail with a working gate as well.

    // Word 0 bit 2: output compare channel 1
    AST_GATE_CMP1: assert property (
        flag_r[IEB_B_CMP1] && prio_on[IEB_B_CMP1]
        |=> irq_req[IEB_B_CMP1] == $past(en_vec[IEB_B_CMP1]))
        else $error("Compare one gate wrong");

    // Word 0 bit 1: input capture channel 1
    AST_GATE_CAP1: assert property (
        flag_r[IEB_B_CAP1] && prio_on[IEB_B_CAP1]
        |=> irq_req[IEB_B_CAP1] == $past(en_vec[IEB_B_CAP1]))
        else $error("Capture one gate wrong");

    // Word 0 bit 0: external pin 0
    AST_GATE_PIN0: assert property (
        flag_r[IEB_B_PIN0] && prio_on[IEB_B_PIN0]
        |=> irq_req[IEB_B_PIN0] == $past(en_vec[IEB_B_PIN0]))
        else $error("External pin zero gate wrong");

    // Word 0 bit 6: output compare channel 2
    AST_GATE_CMP2: assert property (
        flag_r[IEB_B_CMP2] && prio_on[IEB_B_CMP2]
        |=> irq_req[IEB_B_CMP2] == $past(en_vec[IEB_B_CMP2]))
        else $error("Compare two gate wrong");

    // Word 1 bit 14: second serial port receiver
    AST_GATE_SER2RX: assert property (
        flag_r[16+IEB_B_SER2RX] && prio_on[16+IEB_B_SER2RX]
        |=> irq_req[16+IEB_B_SER2RX] == $past(en_vec[16+IEB_B_SER2RX]))
        else $error("Serial two receive gate wrong");

    // Word 1 bit 13: external pin 2
    AST_GATE_PIN2: assert property (
        flag_r[16+IEB_B_PIN2] && prio_on[16+IEB_B_PIN2]
        |=> irq_req[16+IEB_B_PIN2] == $past(en_vec[16+IEB_B_PIN2]))
        else $error("External pin two gate wrong");

    // Word 1 bit 12: timer five
    AST_GATE_TMR5: assert property (
        flag_r[16+IEB_B_TMR5] && prio_on[16+IEB_B_TMR5]
        |=> irq_req[16+IEB_B_TMR5] == $past(en_vec[16+IEB_B_TMR5]))
        else $error("Timer five gate wrong");

    // Word 1 bit 11: timer four
    AST_GATE_TMR4: assert property (
        flag_r[16+IEB_B_TMR4] && prio_on[16+IEB_B_TMR4]
        |=> irq_req[16+IEB_B_TMR4] == $past(en_vec[16+IEB_B_TMR4]))
        else $error("Timer four gate wrong");

    // Word 1 bit 10: output compare channel 4
    AST_GATE_CMP4: assert property (
        flag_r[16+IEB_B_CMP4] && prio_on[16+IEB_B_CMP4]
        |=> irq_req[16+IEB_B_CMP4] == $past(en_vec[16+IEB_B_CMP4]))
        else $error("Compare four gate wrong");

    // Word 1 bit 9: output compare channel 3
    AST_GATE_CMP3: assert property (
        flag_r[16+IEB_B_CMP3] && prio_on[16+IEB_B_CMP3]
        |=> irq_req[16+IEB_B_CMP3] == $past(en_vec[16+IEB_B_CMP3]))
        else $error("Compare three gate wrong");

    // Word 1 bit 8: DMA channel 2 done
    AST_GATE_DMA2: assert property (
        flag_r[16+IEB_B_DMA2] && prio_on[16+IEB_B_DMA2]
        |=> irq_req[16+IEB_B_DMA2] == $past(en_vec[16+IEB_B_DMA2]))
        else $error("DMA two gate wrong");

    // Word 1 bit 4: external pin 1
    AST_GATE_PIN1: assert property (
        flag_r[16+IEB_B_PIN1] && prio_on[16+IEB_B_PIN1]
        |=> irq_req[16+IEB_B_PIN1] == $past(en_vec[16+IEB_B_PIN1]))
        else $error("External pin one gate wrong");

    // Word 1 bit 3: pin change notification
    AST_GATE_PCHG: assert property (
        flag_r[16+IEB_B_PCHG] && prio_on[16+IEB_B_PCHG]
        |=> irq_req[16+IEB_B_PCHG] == $past(en_vec[16+IEB_B_PCHG]))
        else $error("Pin change gate wrong");

    // Word 1 bit 2: analog comparator
    AST_GATE_CMPR: assert property (
        flag_r[16+IEB_B_CMPR] && prio_on[16+IEB_B_CMPR]
        |=> irq_req[16+IEB_B_CMPR] == $past(en_vec[16+IEB_B_CMPR]))
        else $error("Comparator gate wrong");

    // Word 1 bit 1: I2C master events
    AST_GATE_I2CM: assert property (
        flag_r[16+IEB_B_I2CM] && prio_on[16+IEB_B_I2CM]
        |=> irq_req[16+IEB_B_I2CM] == $past(en_vec[16+IEB_B_I2CM]))
        else $error("I2C master gate wrong");

    // Word 1 bit 0: I2C slave events
    AST_GATE_I2CS: assert property (
        flag_r[16+IEB_B_I2CS] && prio_on[16+IEB_B_I2CS]
        |=> irq_req[16+IEB_B_I2CS] == $past(en_vec[16+IEB_B_I2CS]))
        else $error("I2C slave gate wrong");

    // ------------------------------------------------------------
    // Flags, reset and register bus
    // ------------------------------------------------------------
    // A set flag must hold until someone clears it
    AST_FLAG_HOLD: assert property (
        flag_r[16+IEB_B_PCHG] && !flag_clr[16+IEB_B_PCHG]
        |=> flag_r[16+IEB_B_PCHG])
        else $error("Flag dropped without a clear");

    // A clear with no new event empties the flag
    AST_FLAG_CLEAR: assert property (
        flag_clr[IEB_B_CAP1] && !src_event[IEB_B_CAP1]
        |=> !flag_r[IEB_B_CAP1])
        else $error("Flag not cleared");

    // No request may leave in the first cycle after reset
    AST_REQ_RESET: assert property (
        !$past(rst_n) |-> irq_req == '0)
        else $error("Request seen right after reset");

    // Enable word 1 moves only on a write
    AST_EN_HOLD: assert property (
        !wr |=> en_r[1] == $past(en_r[1]))
        else $error("Enable word changed without a write");

    // A status read leaves nothing behind; no event can coincide
    AST_STAT_READ: assert property (
        rd && apb_req.paddr == IEB_OFS_STAT |=> stat_r == 2'b00)
        else $error("Status not cleared by its read");

    // An unmapped setup must answer with an error in its access
    AST_SLVERR: assert property (
        apb_req.psel && !apb_req.penable && !mapped ##1 acc
        |-> apb_rsp.pslverr)
        else $error("Unmapped access gave no error");

    // ------------------------------------------------------------
    // Cover points for the main scenarios
    // ------------------------------------------------------------
    COV_PRIO_SILENCE: cover property (flag_r[IEB_B_PIN0]
                                      && en_vec[IEB_B_PIN0]
                                      && !prio_on[IEB_B_PIN0]);
    COV_ENABLE_WRITE: cover property (wr && apb_req.paddr == IEB_OFS_EN1);
    COV_FORWARD: cover property (irq_req[16+IEB_B_SER2RX]);
    COV_NO_CAN_WRITE: cover property (wr && !can_present
                                      && apb_req.paddr == IEB_OFS_EN2);

endmodule // ieb_enable_bank

// ---- dv/ieb_src_model.sv ----
// Model of the peripheral event sources beside the enable bank.
// Assumes the bank samples its inputs on the rising edge of ref_clk.
`timescale 1ns/1ps
module ieb_src_model
    import ieb_pkg::*;
(
    input wire logic ref_clk, // System clock
    output logic [IEB_SRC-1:0] src_event, // Event pulses
    output logic [IEB_SRC-1:0] flag_clr, // Flag clear pulses
    output logic [3*IEB_SRC-1:0] src_prio // Three bits per source
);
    // ------------------------------------------------------------
    // Quiet at start, every source at a middle priority
    // ------------------------------------------------------------
    initial begin
        src_event = '0;
        flag_clr = '0;
        src_prio = {IEB_SRC{3'h4}};
    end

    // One-cycle pulse; lines drop again so flags must hold by themselves
    task automatic pulse(input logic clr, input logic [IEB_SRC-1:0] m);
        @(posedge ref_clk);
        if (clr) begin
            flag_clr <= m;
        end else begin
            src_event <= m;
        end
        @(posedge ref_clk);
        flag_clr <= '0;
        src_event <= '0;
    endtask

    // Priority field of one source, changed just after an edge
    task automatic prio(input int i, input logic [2:0] p);
        @(posedge ref_clk);
        src_prio[3*i +: 3] <= p;
    endtask
endmodule // ieb_src_model

// ---- dv/test_interrupt_enable_bank.sv ----
// Self-checking bench for the interrupt enable bank over APB.
// Assumes the source model drives events and priorities.
`timescale 1ns/1ps
module test_interrupt_enable_bank import ieb_pkg::*;;
    logic ref_clk = 1'b0; // 25 MHz
    logic rst_n = 1'b0; // Held low at start
    logic can_present = 1'b1; // CAN fitted unless a test says not
    ieb_apb_req_s req = '0; // APB request group
    ieb_apb_rsp_s rsp; // APB answer group
    logic [IEB_SRC-1:0] ev, clr, irq_req, flag_out;
    logic [3*IEB_SRC-1:0] prio; // Priorities from the model
    logic irq; // Block interrupt
    int failures = 0;
    int comparisons = 0;
    logic [31:0] rd; // Last read data
    logic err; // Last error answer
    logic [63:0] impl; // Implemented enable bits, all words
    // Named gates of words 0 and 1, as source index 16*w+b
    int tbl [16] = '{2, 1, 0, 6, 30, 29, 28, 27, 26, 25, 24, 20, 19, 18,
                     17, 16};

    always #20 ref_clk = ~ref_clk;

    ieb_enable_bank dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .can_present(can_present), .apb_req(req), .apb_rsp(rsp),
        .src_event(ev), .flag_clr(clr), .src_prio(prio),
        .irq_req(irq_req), .flag_out(flag_out), .irq(irq));
    ieb_src_model src (.ref_clk(ref_clk), .src_event(ev),
        .flag_clr(clr), .src_prio(prio));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One APB transfer; waits on pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        // A wait that runs out is a mismatch in its own right
        if (rsp.pready !== 1'b1) begin
            failures++;
            $display("unexpected pready: expected 1, seen %b", rsp.pready);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Enable one source alone and see only its request pass
    task automatic gate_one(input int s);
        apb(1'b1, IEB_OFS_EN0 + 8'(4*(s/16)), 32'h1 << (s%16));
        idle(3);
        chk("single gate", 64'h1 << s, irq_req);
        apb(1'b1, IEB_OFS_EN0 + 8'(4*(s/16)), '0);
    endtask

    task automatic close_out();
        $display("counts: %0d comparisons, %0d failures", comparisons,
                 failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        impl = {IEB_IMPL_W3, IEB_IMPL_W2, IEB_IMPL_W1, IEB_IMPL_W0};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            apb(1'b0, IEB_OFS_EN0 + 8'(4*w), '0);
            chk("enable word", 64'h0, 64'(rd));
        end
        $display("test reset done");
        // Events with every enable off: flags rise, nothing passes
        src.pulse(1'b0, '1);
        idle(3);
        chk("flags", impl, flag_out & impl);
        chk("requests", 64'h0, irq_req);
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, IEB_OFS_EN0 + 8'(4*w), 32'hffffffff);
            apb(1'b0, IEB_OFS_EN0 + 8'(4*w), '0);
            chk("readback", 64'(impl[16*w +: 16]), 64'(rd));
        end
        idle(3);
        chk("all gates", impl, irq_req);
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, IEB_OFS_EN0 + 8'(4*w), '0);
        end
        foreach (tbl[i]) begin
            gate_one(tbl[i]);
        end
        $display("test gates done");
        // Zero priority silences an enabled source
        apb(1'b1, IEB_OFS_EN0, 32'h1);
        src.prio(0, IEB_PRIO_OFF);
        idle(3);
        chk("zero priority", 64'h0, irq_req);
        src.prio(0, 3'h4);
        idle(3);
        chk("priority back", 64'h1, irq_req);
        apb(1'b1, IEB_OFS_EN0, '0);
        // CAN gates held off while the controller is absent
        can_present <= 1'b0;
        apb(1'b1, IEB_OFS_EN2, 32'(IEB_CAN_W2));
        apb(1'b0, IEB_OFS_EN2, '0);
        chk("can readback", 64'(IEB_CAN_W2), 64'(rd));
        idle(3);
        chk("can absent", 64'h0, irq_req);
        can_present <= 1'b1;
        idle(3);
        chk("can fitted", 64'(IEB_CAN_W2) << 32, irq_req);
        src.pulse(1'b1, '1);
        idle(3);
        chk("flags cleared", 64'h0, flag_out);
        chk("requests follow", 64'h0, irq_req);
        $display("test priority and can done");
        // Unmapped access: error, masked, then raised and cleared
        apb(1'b0, IEB_OFS_STAT, '0);
        apb(1'b0, 8'h38, '0);
        chk("unmapped error", 64'h1, 64'(err));
        idle(2);
        chk("masked irq", 64'h0, 64'(irq));
        apb(1'b1, IEB_OFS_MASK, 32'h2);
        idle(2);
        chk("irq raised", 64'h1, 64'(irq));
        apb(1'b0, IEB_OFS_STAT, '0);
        chk("status", 64'h2, 64'(rd));
        idle(2);
        chk("irq cleared", 64'h0, 64'(irq));
        $display("test interrupt done");
        close_out();
    end

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #800000;
        failures++;
        close_out();
    end
endmodule // test_interrupt_enable_bank
